// ==== common/pld_pkg.sv ====
package pld_pkg;

	// ----------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------
	localparam int NUM_CELLS      = 8;  // macrocells
	localparam int TERMS_PER_CELL = 8;  // product terms per cell
	localparam int NUM_ROWS       = 64; // product terms in all
	localparam int ROW_BITS       = 6;  // term row index width
	localparam int NUM_COLS       = 32; // true and complement columns
	localparam int COLS_PER_CELL  = 4;  // input pair plus feedback pair
	localparam int SIG_BITS       = 64; // signature word
	localparam int OE_TERM        = 7;  // term used as enable
	localparam int LOWEST_CELL    = 0;  // lowest_edge_cell
	localparam int HIGHEST_CELL   = 7;  // highest_edge_cell
	localparam int NOFB_CELL_A    = 3;  // cell on pin 15
	localparam int NOFB_CELL_B    = 4;  // cell on pin 16
	localparam int MID_CELL       = 4;  // lower half takes upper neighbour

	// ----------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG    = 8'h00;
	localparam logic [7:0] OFS_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_FUSE_ROW  = 8'h0C;
	localparam logic [7:0] OFS_FUSE_DATA = 8'h10;
	localparam logic [7:0] OFS_SIG_LO    = 8'h14;
	localparam logic [7:0] OFS_SIG_HI    = 8'h18;

	// ----------------------------------------------------------
	// field positions
	// ----------------------------------------------------------
	localparam int POS_REG_DIS    = 0;  // global_register_disable
	localparam int POS_EMU        = 1;  // global_emulation_select
	localparam int POS_MODE       = 8;  // cell_mode_select[7:0]
	localparam int POS_POL        = 16; // cell_polarity_select[7:0]
	localparam int POS_ERASE      = 0;  // control: erase strobe
	localparam int POS_PRELOAD    = 1;  // control: preload mode
	localparam int POS_SECURE     = 2;  // control: program security
	localparam int POS_ST_SECURE  = 0;  // status: secured
	localparam int POS_ST_REJECT  = 1;  // status: config refused, w1c
	localparam int POS_ST_PRELOAD = 2;  // status: preload mode
	localparam int POS_ST_REGS    = 8;  // status: flip-flops
	localparam int POS_ST_PINS    = 16; // status: pin drive values
	localparam int HTRANS_ACTIVE  = 1;  // htrans bit set for NONSEQ/SEQ

	// ----------------------------------------------------------
	// reset and erase values
	// ----------------------------------------------------------
	localparam logic          RST_REG_DIS = 1'h1;
	localparam logic          RST_EMU     = 1'h0;
	localparam logic [7:0]    RST_MODE    = 8'h00;
	localparam logic [7:0]    RST_POL     = 8'hFF;
	localparam logic [63:0]   RST_SIG     = 64'h0;

	// cell configurations
	typedef enum logic [2:0] {
		MODE_REGOUT  = 3'h0, // registered output
		MODE_COMBOUT = 3'h1, // dedicated combinatorial output
		MODE_CIO_NRG = 3'h2, // combinatorial I/O, no registers
		MODE_CIO_REG = 3'h3, // combinatorial I/O, registered device
		MODE_INPUT   = 3'h4, // dedicated input
		MODE_BAD     = 3'h7  // undefined combination
	} cell_cfg_t;

	// decode the select bits of one cell
	function automatic cell_cfg_t decode_cell(input logic reg_dis, input logic emu,
		input logic mode_sel, input int idx);
		cell_cfg_t c;
		unique case ({reg_dis, emu, mode_sel})
			3'h2: c = MODE_REGOUT;
			3'h3: c = MODE_CIO_REG;
			3'h4: c = MODE_COMBOUT;
			// pins 15 and 16 have no neighbour to serve as input
			3'h5: c = (idx == NOFB_CELL_A || idx == NOFB_CELL_B) ? MODE_BAD : MODE_INPUT;
			3'h7: c = MODE_CIO_NRG;
			default: c = MODE_BAD;
		endcase
		return c;
	endfunction: decode_cell

endpackage: pld_pkg

// ==== common/array_if.sv ====
// program and evaluate port of the AND array
interface array_if;
	logic                            erase;  // clear every connection
	logic                            wr_en;  // write one term row
	logic [pld_pkg::ROW_BITS-1:0]    row;    // row for write and read
	logic [pld_pkg::NUM_COLS-1:0]    wr_row; // connection mask written
	logic [pld_pkg::NUM_COLS-1:0]    rd_row; // connection mask read
	logic [pld_pkg::NUM_COLS-1:0]    cols;   // array input columns
	logic [pld_pkg::NUM_ROWS-1:0]    terms;  // product term values

	modport host (output erase, wr_en, row, wr_row, cols, input rd_row, terms);
	modport store (input erase, wr_en, row, wr_row, cols, output rd_row, terms);
endinterface: array_if

// ==== rtl/and_array.sv ====
module and_array (
	input  wire logic mclk_in,    // system clock
	input  wire logic reset_n_in, // sync reset, active low
	array_if.store    arr         // program and evaluate port
);

	// ----------------------------------------------------------
	// connection store, 1 = column connected to the term
	// ----------------------------------------------------------
	logic [pld_pkg::NUM_COLS-1:0] fuse_q [pld_pkg::NUM_ROWS]; // stored masks
	logic [pld_pkg::NUM_COLS-1:0] fuse_d [pld_pkg::NUM_ROWS]; // next masks

	// an open column passes, so an empty term is high
	function automatic logic term_value(input logic [pld_pkg::NUM_COLS-1:0] mask,
		input logic [pld_pkg::NUM_COLS-1:0] cols);
		return &(~mask | cols);
	endfunction: term_value

	// next masks: erase wins over a row write
	always_comb begin
		for (int r = 0; r < pld_pkg::NUM_ROWS; r++) begin
			fuse_d[r] = fuse_q[r];
			if (arr.erase) begin
				fuse_d[r] = '0;
			end else if (arr.wr_en && r == int'(arr.row)) begin
				fuse_d[r] = arr.wr_row;
			end
		end
	end

	// reset leaves the array erased
	always_ff @(posedge mclk_in) begin
		for (int r = 0; r < pld_pkg::NUM_ROWS; r++) begin
			if (!reset_n_in) begin
				fuse_q[r] <= '0;
			end else begin
				fuse_q[r] <= fuse_d[r];
			end
		end
	end

	// ----------------------------------------------------------
	// evaluation
	// ----------------------------------------------------------
	always_comb begin
		for (int r = 0; r < pld_pkg::NUM_ROWS; r++) begin
			arr.terms[r] = term_value(fuse_q[r], arr.cols);
		end
	end

	assign arr.rd_row = fuse_q[arr.row]; // readback, gated by the host
endmodule: and_array

// ==== rtl/pld_output_macrocell.sv ====
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
module pld_output_macrocell (
	input  wire logic        mclk_in,       // 10 MHz clock
	input  wire logic        reset_n_in,    // sync power-up reset, active low
	input  wire logic        hsel_in,       // slave select
	input  wire logic [31:0] haddr_in,      // byte address
	input  wire logic [1:0]  htrans_in,     // transfer type
	input  wire logic        hwrite_in,     // write when high
	input  wire logic [2:0]  hsize_in,      // word only, not checked
	input  wire logic [31:0] hwdata_in,     // write data
	input  wire logic        hready_in,     // bus ready
	output logic      [31:0] hrdata_out,    // read data
	output logic             hreadyout_out, // always ready
	output logic             hresp_out,     // always OKAY
	input  wire logic        clk_pin_in,    // register clock pin
	input  wire logic        oe_n_pin_in,   // output enable pin, low active
	input  wire logic [7:0]  in_pins_in,    // dedicated inputs
	input  wire logic [7:0]  io_in,         // io pin levels
	output logic      [7:0]  io_data_out,   // io pin drive values
	output logic      [7:0]  io_oe_out      // io pin drive enables
);

	// ----------------------------------------------------------
	// state and wiring
	// ----------------------------------------------------------
	array_if arr ();                                   // AND array port
	logic                   reg_dis_q, reg_dis_d;      // global_register_disable
	logic                   emu_q, emu_d;              // global_emulation_select
	logic [7:0]             mode_q, mode_d;            // cell_mode_select
	logic [7:0]             pol_q, pol_d;              // cell_polarity_select
	logic                   secure_q, secure_d;        // security bit
	logic                   reject_q, reject_d;        // config refused, sticky
	logic                   preload_q, preload_d;      // preload mode
	logic [5:0]             row_q, row_d;              // fuse row pointer
	logic [63:0]            sig_q, sig_d;              // signature word
	logic                   wr_pend_q, wr_pend_d;      // write data phase due
	logic [7:0]             wr_addr_q, wr_addr_d;      // write offset
	logic [31:0]            rdata_q, rdata_d;          // read data
	logic                   ready_q, resp_q;           // fixed answers
	logic                   clk_prev_q, clk_prev_d;    // clock pin last level
	logic [7:0]             ff_q, ff_d;                // cell flip-flops
	logic [7:0]             pin_q, pin_d;              // pin values
	logic [7:0]             oe_q, oe_d;                // pin enables
	pld_pkg::cell_cfg_t     cfg_c [pld_pkg::NUM_CELLS];  // live cell modes
	pld_pkg::cell_cfg_t     cand_c [pld_pkg::NUM_CELLS]; // modes being written
	logic                   cand_ok_c;                 // write is legal
	logic [7:0]             fb_c;                      // feedback per cell
	logic [7:0]             sum8_c, sum7_c, oe_pt_c;   // sums and enable term
	logic                   clk_rise_c;                // clock pin rising
	logic                   addr_ph_c;                 // address phase taken
	logic                   erase_c;                   // erase strobe

	and_array u_array (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.arr        (arr.store)
	);

	// ----------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------
	always_comb begin
		cand_ok_c = 1'h1;
		for (int x = 0; x < pld_pkg::NUM_CELLS; x++) begin
			cfg_c[x] = pld_pkg::decode_cell(reg_dis_q, emu_q, mode_q[x], x);
			cand_c[x] = pld_pkg::decode_cell(hwdata_in[pld_pkg::POS_REG_DIS],
				hwdata_in[pld_pkg::POS_EMU], hwdata_in[pld_pkg::POS_MODE + x], x);
			if (cand_c[x] == pld_pkg::MODE_BAD) begin
				cand_ok_c = 1'h0;
			end
		end
	end

	// ----------------------------------------------------------
	// feedback, array columns and sums
	// ----------------------------------------------------------
	// pin drive values are registered, so no loop closes through the array
	always_comb begin
		logic sel;
		sel = 1'h0;
		for (int x = 0; x < pld_pkg::NUM_CELLS; x++) begin
			if (x == pld_pkg::LOWEST_CELL || x == pld_pkg::HIGHEST_CELL) begin
				sel = !reg_dis_q;
			end else begin
				sel = emu_q;
			end
			if (sel) begin
				// own pin for I/O, inverted flip-flop when registered
				fb_c[x] = mode_q[x] ? io_in[x] : !ff_q[x];
			end else if (x == pld_pkg::HIGHEST_CELL) begin
				fb_c[x] = clk_pin_in;
			end else if (x == pld_pkg::LOWEST_CELL) begin
				fb_c[x] = oe_n_pin_in;
			end else if (x == pld_pkg::NOFB_CELL_A || x == pld_pkg::NOFB_CELL_B) begin
				fb_c[x] = 1'h0;
			end else if (x < pld_pkg::MID_CELL) begin
				fb_c[x] = io_in[x + 1];
			end else begin
				fb_c[x] = io_in[x - 1];
			end
			arr.cols[x * pld_pkg::COLS_PER_CELL]     = in_pins_in[x];
			arr.cols[x * pld_pkg::COLS_PER_CELL + 1] = !in_pins_in[x];
			arr.cols[x * pld_pkg::COLS_PER_CELL + 2] = fb_c[x];
			arr.cols[x * pld_pkg::COLS_PER_CELL + 3] = !fb_c[x];
			sum8_c[x] = |arr.terms[x * pld_pkg::TERMS_PER_CELL +: pld_pkg::TERMS_PER_CELL];
			sum7_c[x] = |arr.terms[x * pld_pkg::TERMS_PER_CELL +: pld_pkg::OE_TERM];
			oe_pt_c[x] = arr.terms[x * pld_pkg::TERMS_PER_CELL + pld_pkg::OE_TERM];
		end
	end

	// ----------------------------------------------------------
	// macrocell outputs and flip-flops
	// ----------------------------------------------------------
	always_comb begin
		clk_prev_d = clk_pin_in;
		clk_rise_c = clk_pin_in && !clk_prev_q;
		for (int x = 0; x < pld_pkg::NUM_CELLS; x++) begin
			ff_d[x] = ff_q[x];
			unique case (cfg_c[x])
				pld_pkg::MODE_REGOUT: begin
					// pin shows the inverted flip-flop, so cleared state reads HIGH
					pin_d[x] = !ff_q[x];
					oe_d[x] = !oe_n_pin_in;
					if (clk_rise_c) begin
						// preload takes the level the tester drives on the pin
						ff_d[x] = preload_q ? io_in[x] : (sum8_c[x] ^ pol_q[x]);
					end
				end
				pld_pkg::MODE_COMBOUT: begin
					pin_d[x] = sum8_c[x] ~^ pol_q[x];
					oe_d[x] = 1'h1;
				end
				pld_pkg::MODE_CIO_NRG, pld_pkg::MODE_CIO_REG: begin
					pin_d[x] = sum7_c[x] ~^ pol_q[x];
					oe_d[x] = oe_pt_c[x];
				end
				default: begin
					// input and refused codes never drive
					pin_d[x] = 1'h0;
					oe_d[x] = 1'h0;
				end
			endcase
			if (preload_q) begin
				oe_d[x] = 1'h0;
			end
		end
	end

	// flip-flops clear at power-up
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ff_q <= 8'h00;
			pin_q <= 8'h00;
			oe_q <= 8'h00;
			clk_prev_q <= 1'h0;
		end else begin
			ff_q <= ff_d;
			pin_q <= pin_d;
			oe_q <= oe_d;
			clk_prev_q <= clk_prev_d;
		end
	end

	// ----------------------------------------------------------
	// bus slave: zero wait states, reads registered at address phase
	// ----------------------------------------------------------
	always_comb begin
		addr_ph_c = hsel_in && hready_in && htrans_in[pld_pkg::HTRANS_ACTIVE];
		wr_pend_d = addr_ph_c && hwrite_in;
		wr_addr_d = haddr_in[7:0];
		rdata_d = 32'h0000_0000;
		if (addr_ph_c && !hwrite_in) begin
			unique case (haddr_in[7:0])
				pld_pkg::OFS_CONFIG: begin
					if (!secure_q) begin
						rdata_d[pld_pkg::POS_REG_DIS] = reg_dis_q;
						rdata_d[pld_pkg::POS_EMU] = emu_q;
						rdata_d[pld_pkg::POS_MODE +: 8] = mode_q;
						rdata_d[pld_pkg::POS_POL +: 8] = pol_q;
					end
				end
				pld_pkg::OFS_CONTROL: rdata_d[pld_pkg::POS_PRELOAD] = preload_q;
				pld_pkg::OFS_STATUS: begin
					rdata_d[pld_pkg::POS_ST_SECURE] = secure_q;
					rdata_d[pld_pkg::POS_ST_REJECT] = reject_q;
					rdata_d[pld_pkg::POS_ST_PRELOAD] = preload_q;
					rdata_d[pld_pkg::POS_ST_REGS +: 8] = ff_q;
					rdata_d[pld_pkg::POS_ST_PINS +: 8] = pin_q;
				end
				pld_pkg::OFS_FUSE_ROW: rdata_d[pld_pkg::ROW_BITS-1:0] = row_q;
				pld_pkg::OFS_FUSE_DATA: rdata_d = secure_q ? 32'h0000_0000 : arr.rd_row;
				pld_pkg::OFS_SIG_LO: rdata_d = sig_q[31:0];
				pld_pkg::OFS_SIG_HI: rdata_d = sig_q[63:32];
				default: rdata_d = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'h1;
			resp_q <= 1'h0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q <= rdata_d;
			ready_q <= 1'h1;
			resp_q <= 1'h0;
		end
	end

	// ----------------------------------------------------------
	// register writes in the data phase
	// ----------------------------------------------------------
	always_comb begin
		reg_dis_d = reg_dis_q;
		emu_d = emu_q;
		mode_d = mode_q;
		pol_d = pol_q;
		secure_d = secure_q;
		reject_d = reject_q;
		preload_d = preload_q;
		row_d = row_q;
		sig_d = sig_q;
		erase_c = wr_pend_q && wr_addr_q == pld_pkg::OFS_CONTROL
			&& hwdata_in[pld_pkg::POS_ERASE];
		arr.erase = erase_c;
		arr.wr_en = wr_pend_q && wr_addr_q == pld_pkg::OFS_FUSE_DATA && !secure_q;
		arr.wr_row = hwdata_in;
		arr.row = row_q;
		if (wr_pend_q) begin
			unique case (wr_addr_q)
				pld_pkg::OFS_CONFIG: begin
					// a secured pattern must be erased before it changes
					if (!secure_q && cand_ok_c) begin
						reg_dis_d = hwdata_in[pld_pkg::POS_REG_DIS];
						emu_d = hwdata_in[pld_pkg::POS_EMU];
						mode_d = hwdata_in[pld_pkg::POS_MODE +: 8];
						pol_d = hwdata_in[pld_pkg::POS_POL +: 8];
					end else if (!secure_q) begin
						reject_d = 1'h1;
					end
				end
				pld_pkg::OFS_CONTROL: preload_d = hwdata_in[pld_pkg::POS_PRELOAD];
				pld_pkg::OFS_STATUS: begin
					if (hwdata_in[pld_pkg::POS_ST_REJECT]) begin
						reject_d = 1'h0;
					end
				end
				pld_pkg::OFS_FUSE_ROW: row_d = hwdata_in[pld_pkg::ROW_BITS-1:0];
				pld_pkg::OFS_SIG_LO: sig_d[31:0] = hwdata_in;
				pld_pkg::OFS_SIG_HI: sig_d[63:32] = hwdata_in;
				default: ; // fuse data and unmapped: nothing held here
			endcase
		end
		if (erase_c) begin
			// erase and power-up reset are the only ways back to an unsecured device
			reg_dis_d = pld_pkg::RST_REG_DIS;
			emu_d = pld_pkg::RST_EMU;
			mode_d = pld_pkg::RST_MODE;
			pol_d = pld_pkg::RST_POL;
			secure_d = 1'h0;
			sig_d = pld_pkg::RST_SIG;
		end
		if (wr_pend_q && wr_addr_q == pld_pkg::OFS_CONTROL && hwdata_in[pld_pkg::POS_SECURE]) begin
			secure_d = 1'h1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			reg_dis_q <= pld_pkg::RST_REG_DIS;
			emu_q <= pld_pkg::RST_EMU;
			mode_q <= pld_pkg::RST_MODE;
			pol_q <= pld_pkg::RST_POL;
			secure_q <= 1'h0;
			reject_q <= 1'h0;
			preload_q <= 1'h0;
			row_q <= 6'h00;
			sig_q <= pld_pkg::RST_SIG;
		end else begin
			reg_dis_q <= reg_dis_d;
			emu_q <= emu_d;
			mode_q <= mode_d;
			pol_q <= pol_d;
			secure_q <= secure_d;
			reject_q <= reject_d;
			preload_q <= preload_d;
			row_q <= row_d;
			sig_q <= sig_d;
		end
	end

	assign hrdata_out = rdata_q;
	assign hreadyout_out = ready_q;
	assign hresp_out = resp_q;
	assign io_data_out = pin_q;
	assign io_oe_out = oe_q;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_reg_edge;
		cfg_c[0] == pld_pkg::MODE_REGOUT && clk_rise_c && !preload_q;
	endsequence
	sequence s_reg_shown;
		cfg_c[0] != pld_pkg::MODE_REGOUT || preload_q || io_data_out[0] == !$past(ff_q[0]);
	endsequence

	a_combout_sum: assert property (
		cfg_c[1] == pld_pkg::MODE_COMBOUT && !preload_q
		|=> io_oe_out[1] && io_data_out[1] == ($past(sum8_c[1]) ~^ $past(pol_q[1])))
		else $error("combinatorial output does not follow the sum");
	a_mid_no_fb: assert property (
		cfg_c[3] == pld_pkg::MODE_COMBOUT |-> !fb_c[3] && !fb_c[4])
		else $error("pins 15 and 16 feed back in output mode");
	a_pins_as_inputs: assert property (
		reg_dis_q |-> fb_c[7] == clk_pin_in && fb_c[0] == oe_n_pin_in)
		else $error("clock or enable pin not routed as input");
	a_cio_enable: assert property (
		(cfg_c[2] == pld_pkg::MODE_CIO_NRG || cfg_c[2] == pld_pkg::MODE_CIO_REG) && !preload_q
		|=> io_oe_out[2] == $past(oe_pt_c[2]) && io_data_out[2] == ($past(sum7_c[2]) ~^ $past(pol_q[2])))
		else $error("I/O cell enable or sum wrong");
	a_pin_feedback: assert property (
		(cfg_c[2] == pld_pkg::MODE_CIO_NRG || cfg_c[2] == pld_pkg::MODE_CIO_REG) |-> fb_c[2] == io_in[2])
		else $error("I/O cell feedback not from its pin");
	a_input_off: assert property (
		cfg_c[1] == pld_pkg::MODE_INPUT |=> !io_oe_out[1])
		else $error("dedicated input drives its pin");
	a_input_adjacent: assert property (
		cfg_c[1] == pld_pkg::MODE_INPUT |-> fb_c[1] == io_in[2])
		else $error("dedicated input not from adjacent pin");
	a_reg_capture: assert property (
		s_reg_edge |=> (ff_q[0] == ($past(sum8_c[0]) ^ $past(pol_q[0]))) ##1 s_reg_shown)
		else $error("registered cell capture wrong");
	a_power_up_low: assert property (disable iff (1'h0)
		!reset_n_in |=> ff_q == 8'h00 && io_oe_out == 8'h00)
		else $error("flip-flops not low after reset");
	a_preload_load: assert property (
		preload_q && clk_rise_c && cfg_c[0] == pld_pkg::MODE_REGOUT |=> ff_q[0] == $past(io_in[0]))
		else $error("preload did not take the pin level");
	a_secure_read: assert property (
		secure_q && addr_ph_c && !hwrite_in && haddr_in[7:0] == pld_pkg::OFS_FUSE_DATA
		|=> hrdata_out == 32'h0000_0000)
		else $error("secured pattern was read back");
	a_secure_sticky: assert property (
		secure_q && !erase_c |=> secure_q)
		else $error("security cleared without erase");
	a_sig_read: assert property (
		addr_ph_c && !hwrite_in && haddr_in[7:0] == pld_pkg::OFS_SIG_HI
		|=> hrdata_out == $past(sig_q[63:32]))
		else $error("signature read wrong");
	a_reject_bad: assert property (
		wr_pend_q && wr_addr_q == pld_pkg::OFS_CONFIG && !secure_q && !cand_ok_c
		|=> reject_q && $stable(mode_q) && $stable(reg_dis_q))
		else $error("undefined configuration accepted");
endmodule: pld_output_macrocell

// ==== test/pld_output_macrocell_tb.sv ====
module pld_output_macrocell_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// stimulus and wiring
	// ------------------------------------------------
	logic        mclk    = 1'h0;  // bench clock
	logic        rst_n   = 1'h0;  // reset, active low
	logic        hsel    = 1'h0;  // bus select
	logic        hwrite  = 1'h0;  // bus direction
	logic        clk_pin = 1'h0;  // register clock pin
	logic        oe_n    = 1'h0;  // enable pin, active low
	logic [1:0]  htrans  = 2'h0;  // transfer type
	logic [31:0] haddr   = 32'h0; // byte address
	logic [31:0] hwdata  = 32'h0; // write data
	logic [31:0] rd;              // last read word
	logic [7:0]  ext     = 8'h0;  // level forced by the outside world
	wire  [31:0] hrdata;          // read data
	wire         hready;          // one slave: its ready is the bus ready
	wire         hresp;           // response, checked for OKAY after every transfer
	wire  [7:0]  io_d;            // pin drive values
	wire  [7:0]  io_oe;           // pin drive enables
	wire  [7:0]  io_w;            // resolved pin level
	int          n_fail = 0;      // mismatches
	int          check_count = 0; // comparisons
	// the device wins a pin wherever it drives it
	assign io_w = (io_d & io_oe) | (ext & ~io_oe);
	pld_output_macrocell i_pld_output_macrocell (.mclk_in(mclk), .reset_n_in(rst_n),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .clk_pin_in(clk_pin),
		.oe_n_pin_in(oe_n), .in_pins_in(8'h0), .io_in(io_w), .io_data_out(io_d),
		.io_oe_out(io_oe));
	always #50 mclk = ~mclk;
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic stop_test();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask: stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask: chk
	// wait for ready at a rising edge; a hung slave ends the run
	task automatic rdy();
		int i;
		i = 0;
		@(posedge mclk);
		while (hready !== 1'h1 && i < 20) begin
			@(posedge mclk);
			i++;
		end
		if (i >= 20) begin
			n_fail++;
			stop_test();
		end
	endtask: rdy
	// one single word transfer; read data taken at the data phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask: bus
	// one rising edge on the register clock pin, then let pins settle
	task automatic pulse();
		clk_pin <= 1'h1;
		repeat (3) @(posedge mclk);
		clk_pin <= 1'h0;
		repeat (2) @(posedge mclk);
	endtask: pulse
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		bus(1'h0, pld_pkg::OFS_CONFIG, 32'h0);
		chk(rd, 32'h00FF0001);
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h1);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFF00);
		// all selects low is no legal cell setting
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h0);
		bus(1'h0, pld_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h2, 32'h2);
		bus(1'h0, pld_pkg::OFS_CONFIG, 32'h0);
		chk(rd, 32'h1);
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h00FF0002);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		pulse();
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		oe_n <= 1'h1;
		repeat (2) @(posedge mclk);
		chk({24'h0, io_oe}, 32'h0);
		bus(1'h1, pld_pkg::OFS_CONTROL, 32'h2);
		ext <= 8'hA5;
		pulse();
		bus(1'h0, pld_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hFF00, 32'hA500);
		bus(1'h1, pld_pkg::OFS_CONTROL, 32'h0);
		oe_n <= 1'h0;
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFF5A);
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h00FFE701);
		repeat (2) @(posedge mclk);
		chk({24'h0, io_oe}, 32'h18);
		// clear the refusal flag, then run every cell as I/O without registers
		bus(1'h1, pld_pkg::OFS_STATUS, 32'h2);
		bus(1'h0, pld_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h2, 32'h0);
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h00FFFF03);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		// enable term of cell 2 holds both forms of input 0, so it goes low
		bus(1'h1, pld_pkg::OFS_FUSE_ROW, 32'h17);
		bus(1'h1, pld_pkg::OFS_FUSE_DATA, 32'h3);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFBFF);
		bus(1'h0, pld_pkg::OFS_FUSE_DATA, 32'h0);
		chk(rd, 32'h3);
		// enable term now follows pin 2, which the outside holds high
		bus(1'h1, pld_pkg::OFS_FUSE_DATA, 32'h400);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		// registered device: the pin, not the set flip-flop, keeps it enabled
		bus(1'h1, pld_pkg::OFS_CONFIG, 32'h00FFFF02);
		repeat (2) @(posedge mclk);
		chk({16'h0, io_oe, io_d}, 32'hFFFF);
		bus(1'h1, pld_pkg::OFS_SIG_LO, 32'h12345678);
		bus(1'h1, pld_pkg::OFS_SIG_HI, 32'h9ABCDEF0);
		bus(1'h1, pld_pkg::OFS_CONTROL, 32'h4);
		bus(1'h0, pld_pkg::OFS_SIG_HI, 32'h0);
		chk(rd, 32'h9ABCDEF0);
		bus(1'h0, pld_pkg::OFS_SIG_LO, 32'h0);
		chk(rd, 32'h12345678);
		bus(1'h0, pld_pkg::OFS_CONFIG, 32'h0);
		chk(rd, 32'h0);
		bus(1'h0, pld_pkg::OFS_FUSE_DATA, 32'h0);
		chk(rd, 32'h0);
		bus(1'h1, pld_pkg::OFS_CONTROL, 32'h1);
		bus(1'h0, pld_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h0);
		bus(1'h0, pld_pkg::OFS_CONFIG, 32'h0);
		chk(rd, 32'h00FF0001);
		bus(1'h0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		// a second power-up clears the flip-flops that preload left set
		rst_n <= 1'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		bus(1'h0, pld_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hFF00, 32'h0);
		stop_test();
	end
endmodule: pld_output_macrocell_tb
